/* File: verilog/task_page_mapper_consts.vh */
// Constants for the task page mapper: register offsets, fields, reset values.
`ifndef TASK_PAGE_MAPPER_CONSTS_VH
`define TASK_PAGE_MAPPER_CONSTS_VH
`define TPM_OFS_KEY_LO 7'h40
`define TPM_OFS_KEY_HI 7'h47
`define TPM_OFS_SBIT 7'h48
`define TPM_OFS_FUSE 7'h49
`define TPM_OFS_ACCESS 7'h4A
`define TPM_OFS_OPERATE 7'h4B
`define TPM_RESET_PAGE 10'h3FF
`define TPM_DMA_TASK 5'h01
`define TPM_SUPER_TASK 5'h00
`define TPM_KEY_RESET 3'h0
`define TPM_TASK_RESET 5'h00
`define TPM_BUS_RUN 2'h0
`define TPM_BUS_IACK 2'h1
`define TPM_BUS_DMA 2'h3
`endif

/* File: verilog/map_ram.v */
// Mapping RAM: 32 page entries for each of four tasks, ten bits each.
`timescale 1ns/1ps
module map_ram #(
  parameter ENTRIES = 128
) (
  // Clock.
  input wire clk,
  // Software port, one byte half of an entry.
  input wire [6:0] sw_index,
  input wire sw_high,
  input wire sw_we,
  input wire [7:0] sw_wdata,
  output wire [7:0] sw_rdata,
  // Translation port.
  input wire [6:0] map_index,
  output wire [9:0] map_page
);
  reg [9:0] mem [0:ENTRIES-1];
  wire [9:0] sw_word;
  // ============================================================
  // Byte writes into the ten bit entries.
  always @(posedge clk) begin
    if (sw_we) begin
      if (sw_high) begin
        mem[sw_index] <= {sw_wdata[1:0], mem[sw_index][7:0]};
      end else begin
        mem[sw_index] <= {mem[sw_index][9:8], sw_wdata};
      end
    end
  end
  assign sw_word = mem[sw_index];
  assign sw_rdata = sw_high ? {6'h00, sw_word[9:8]} : sw_word[7:0];
  assign map_page = mem[map_index];
endmodule // map_ram

/* File: verilog/task_page_mapper.v */
// Task page mapper: per-cycle page translation with task keys and registers.
// ============================================================
// Summary of operation
// - Drive a mapped page each bus cycle; the key-matching unit drives, and every unit drives page 3FF on register access or before the identifier write.
// - Bus grant and phase both high is DMA, both low is running.
// - Registers selected only with window select low, task zero, page inputs ones.
// - Chip group identifier read needs task zero, page ones, bytes 40-47, key select low.
// - Chip group identifier write also needs the supervisor flag.
// - Reset sets a flag forcing page 3FF until the identifier is first written.
// - Each cycle the page comes from logical page and current task.
// - Interrupts, DMA and reset override the current task automatically.
// - Register accesses output page 3FF on all mapped page lines.
// - Register access needs task zero, page ones, defined byte; writes need flag.
// - The first 64 bytes view the map chosen by the view-task register.
// - Bytes 4C through 7F ignore reads and writes.
// - Reset clears view task, current task and identifier, sets the flag.
// - Unused bits of defined registers read zero.
// - Only the view-matching unit answers 48-4B reads; writes go to all.
// - Each 2K page maps through a ten bit byte pair, 32 pairs.
// - Mapping responds only when current task top bits equal the identifier.
// - Map bytes 0-3F are visible only when identifier equals view task top bits.
// - Control writes update every unit; map writes only the matching unit.
// - Each unit holds 1280 bits of map, 10-bit and 2/8-bit views.
// - DMA forces task 1; the supervisor flag forces task 0.
// - Reset and interrupts set the supervisor flag; it is read-only.
// - Switch-delay write loads a counter; on running out the flag clears.
`timescale 1ns/1ps
`include "task_page_mapper_consts.vh"
module task_page_mapper (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Processor bus strobe marking the end of each bus cycle.
  input wire bus_cycle_end,
  input wire read_not_write,
  input wire bus_grant,
  input wire bus_phase_flag,
  input wire reset_n,
  // Address and register select.
  input wire [4:0] logical_page_in,
  input wire register_window_select_n,
  input wire key_value_select_n,
  input wire [6:0] register_byte_select,
  // Data bus.
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe,
  // Mapped page.
  output reg [9:0] mapped_page_out,
  output reg mapped_page_oe
);
  // ============================================================
  // Input synchronisers.
  reg [1:0] end_s1_r;
  reg [1:0] end_s2_r;
  reg [1:0] ctl_s1_r;
  reg [1:0] ctl_s2_r;
  reg rw_s1_r;
  reg rw_s2_r;
  reg rwin_s1_r;
  reg rwin_s2_r;
  reg key_s1_r;
  reg key_s2_r;
  reg rstn_s1_r;
  reg rstn_s2_r;
  reg [4:0] page_s1_r;
  reg [4:0] page_s2_r;
  reg [6:0] sel_s1_r;
  reg [6:0] sel_s2_r;
  reg [7:0] din_s1_r;
  reg [7:0] din_s2_r;
  reg end_d_r;
  // Bus cycle strobe.
  always @(posedge clk) begin
    end_s1_r <= {end_s1_r[0], bus_cycle_end};
    end_s2_r <= end_s1_r;
  end
  // Bus grant and bus phase.
  always @(posedge clk) begin
    ctl_s1_r <= {bus_grant, bus_phase_flag};
    ctl_s2_r <= ctl_s1_r;
  end
  // Read or write.
  always @(posedge clk) begin
    rw_s1_r <= read_not_write;
    rw_s2_r <= rw_s1_r;
  end
  // Register window select.
  always @(posedge clk) begin
    rwin_s1_r <= register_window_select_n;
    rwin_s2_r <= rwin_s1_r;
  end
  // Identifier select.
  always @(posedge clk) begin
    key_s1_r <= key_value_select_n;
    key_s2_r <= key_s1_r;
  end
  // Reset pin.
  always @(posedge clk) begin
    rstn_s1_r <= reset_n;
    rstn_s2_r <= rstn_s1_r;
  end
  // Logical page.
  always @(posedge clk) begin
    page_s1_r <= logical_page_in;
    page_s2_r <= page_s1_r;
  end
  // Register byte select.
  always @(posedge clk) begin
    sel_s1_r <= register_byte_select;
    sel_s2_r <= sel_s1_r;
  end
  // Write data.
  always @(posedge clk) begin
    din_s1_r <= data_in;
    din_s2_r <= din_s1_r;
  end
  // Strobe edge detector.
  always @(posedge clk) begin
    end_d_r <= end_s2_r[1];
  end
  wire cyc_end = end_s2_r[1] & ~end_d_r;
  // ============================================================
  // Cycle classification.
  wire is_dma = (ctl_s2_r == `TPM_BUS_DMA);
  wire is_run = (ctl_s2_r == `TPM_BUS_RUN);
  wire is_iack = (ctl_s2_r == `TPM_BUS_IACK);
  wire pin_reset = ~rstn_s2_r | rst;
  // ============================================================
  // Control registers.
  reg [2:0] key_r;
  reg [2:0] key_nxt;
  reg [4:0] view_r;
  reg [4:0] view_nxt;
  reg [4:0] oper_r;
  reg [4:0] oper_nxt;
  reg sbit_r;
  reg sbit_nxt;
  reg boot_r;
  reg boot_nxt;
  reg [2:0] fuse_r;
  reg [2:0] fuse_nxt;
  reg fuse_on_r;
  reg fuse_on_nxt;
  // Active task with automatic overrides.
  reg [4:0] task_now;
  always @* begin
    task_now = oper_r;
    if (is_dma) begin
      task_now = `TPM_DMA_TASK;
    end else if (sbit_r) begin
      task_now = `TPM_SUPER_TASK;
    end
  end
  wire win = ~rwin_s2_r && (task_now == `TPM_SUPER_TASK) && (&page_s2_r);
  wire sel_ram = win && ~sel_s2_r[6];
  wire sel_key = win && (sel_s2_r >= `TPM_OFS_KEY_LO) && (sel_s2_r <= `TPM_OFS_KEY_HI)
                 && ~key_s2_r;
  wire sel_ctl = win && (sel_s2_r >= `TPM_OFS_SBIT) && (sel_s2_r <= `TPM_OFS_OPERATE);
  wire reg_hit = sel_ram | sel_key | sel_ctl;
  wire view_match = (key_r == view_r[4:2]);
  wire wr_ok = ~rw_s2_r && sbit_r;
  wire do_write = cyc_end && wr_ok;
  // ============================================================
  // Write strobes and counter events.
  wire wr_key = do_write && sel_key;
  wire wr_view = do_write && sel_ctl && (sel_s2_r == `TPM_OFS_ACCESS);
  wire wr_oper = do_write && sel_ctl && (sel_s2_r == `TPM_OFS_OPERATE);
  wire wr_fuse = do_write && sel_ctl && (sel_s2_r == `TPM_OFS_FUSE);
  wire fuse_tick = cyc_end && fuse_on_r && ~is_dma;
  wire iack_end = cyc_end && is_iack;
  // ============================================================
  // Mapping RAM.
  wire [7:0] ram_rdata;
  wire [9:0] ram_page;
  map_ram #(
    .ENTRIES(128)
  ) u_map_ram (
    .clk(clk),
    .sw_index({view_r[1:0], sel_s2_r[5:1]}),
    .sw_high(~sel_s2_r[0]),
    .sw_we(do_write && sel_ram && view_match),
    .sw_wdata(din_s2_r),
    .sw_rdata(ram_rdata),
    .map_index({task_now[1:0], page_s2_r}),
    .map_page(ram_page)
  );
  // ============================================================
  // Next values of the control registers; an interrupt wins over the counter.
  always @* begin
    key_nxt = key_r;
    view_nxt = view_r;
    oper_nxt = oper_r;
    sbit_nxt = sbit_r;
    boot_nxt = boot_r;
    fuse_nxt = fuse_r;
    fuse_on_nxt = fuse_on_r;
    if (wr_key) begin
      key_nxt = din_s2_r[2:0];
      boot_nxt = 1'b0;
    end
    if (wr_view) begin
      view_nxt = din_s2_r[4:0];
    end
    if (wr_oper) begin
      oper_nxt = din_s2_r[4:0];
    end
    if (wr_fuse) begin
      fuse_nxt = din_s2_r[2:0];
      fuse_on_nxt = 1'b1;
    end else if (fuse_tick) begin
      if (fuse_r == 3'h0) begin
        fuse_on_nxt = 1'b0;
        sbit_nxt = 1'b0;
      end else begin
        fuse_nxt = fuse_r - 3'h1;
      end
    end
    if (iack_end) begin
      sbit_nxt = 1'b1;
      fuse_on_nxt = 1'b0;
    end
  end
  // ============================================================
  // Control registers, loaded with their reset values by either reset source.
  always @(posedge clk) begin
    if (pin_reset) begin
      key_r <= `TPM_KEY_RESET;
      view_r <= `TPM_TASK_RESET;
      oper_r <= `TPM_TASK_RESET;
      sbit_r <= 1'b1;
      boot_r <= 1'b1;
      fuse_r <= 3'h0;
      fuse_on_r <= 1'b0;
    end else begin
      key_r <= key_nxt;
      view_r <= view_nxt;
      oper_r <= oper_nxt;
      sbit_r <= sbit_nxt;
      boot_r <= boot_nxt;
      fuse_r <= fuse_nxt;
      fuse_on_r <= fuse_on_nxt;
    end
  end
  // ============================================================
  // Register read values, unused bits zero.
  wire [7:0] key_rd = {5'h00, key_r};
  wire [7:0] sbit_rd = {7'h00, sbit_r};
  wire [7:0] fuse_rd = {5'h00, fuse_r};
  wire [7:0] view_rd = {3'h0, view_r};
  wire [7:0] oper_rd = {3'h0, oper_r};
  // ============================================================
  // Read data and data bus enable.
  reg [7:0] rd_nxt;
  reg rd_en_nxt;
  always @* begin
    rd_nxt = 8'h00;
    rd_en_nxt = 1'b0;
    if (rw_s2_r && sel_ram && view_match) begin
      rd_nxt = ram_rdata;
      rd_en_nxt = 1'b1;
    end else if (rw_s2_r && sel_key) begin
      rd_nxt = key_rd;
      rd_en_nxt = 1'b1;
    end else if (rw_s2_r && sel_ctl && view_match) begin
      rd_en_nxt = 1'b1;
      if (sel_s2_r == `TPM_OFS_SBIT) begin
        rd_nxt = sbit_rd;
      end else if (sel_s2_r == `TPM_OFS_FUSE) begin
        rd_nxt = fuse_rd;
      end else if (sel_s2_r == `TPM_OFS_ACCESS) begin
        rd_nxt = view_rd;
      end else begin
        rd_nxt = oper_rd;
      end
    end
  end
  // ============================================================
  // Next mapped page and its enable.
  reg [9:0] page_nxt;
  reg page_oe_nxt;
  always @* begin
    page_nxt = ram_page;
    page_oe_nxt = (task_now[4:2] == key_r);
    if (boot_r || reg_hit) begin
      page_nxt = `TPM_RESET_PAGE;
      page_oe_nxt = 1'b1;
    end
  end
  // ============================================================
  // Output registers.
  always @(posedge clk) begin
    if (pin_reset) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
      mapped_page_out <= `TPM_RESET_PAGE;
      mapped_page_oe <= 1'b1;
    end else begin
      data_out <= rd_nxt;
      data_oe <= rd_en_nxt;
      mapped_page_out <= page_nxt;
      mapped_page_oe <= page_oe_nxt;
    end
  end
endmodule // task_page_mapper

/* File: dv/cpu_bus_model.sv */
// Processor bus model that runs bus cycles into the page mapper.
`timescale 1ns/1ps
module cpu_bus_model (
  // Clock.
  input wire clk,
  // Bus cycle outputs.
  output logic strobe,
  output logic rnw,
  output logic [1:0] bst,
  output logic pin_rst_n,
  output logic [4:0] page,
  output logic ra_n,
  output logic kva_n,
  output logic [6:0] rs,
  output logic [7:0] wd
);
  initial begin
    {strobe, rnw, bst, page, ra_n, kva_n, rs, wd} = {9'h080, 2'h3, 15'h0000};
    pin_rst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 pin_rst_n = 1'b1;
  end
  // One bus cycle; window select stays off in DMA cycles.
  task automatic cyc(input logic [1:0] s, input logic r, input logic [4:0] p,
      input logic a, input logic k, input logic [6:0] b, input logic [7:0] d);
    @(posedge clk);
    #1 {bst, rnw, page, ra_n, kva_n, rs} = {s, r, p, a | (&s), k, b};
    wd = r ? ~wd : d;
    repeat (5) @(posedge clk);
    #1 strobe = 1'b1;
    repeat (7) @(posedge clk);
    #1 strobe = 1'b0;
  endtask
endmodule // cpu_bus_model

/* File: dv/task_page_mapper_chk.sv */
// Port checker for the task page mapper.
`timescale 1ns/1ps
module task_page_mapper_chk (
  // Clock, reset and inputs.
  input wire clk,
  input wire rst,
  input wire bus_cycle_end,
  input wire bus_grant,
  input wire bus_phase_flag,
  input wire reset_n,
  input wire read_not_write,
  input wire register_window_select_n,
  input wire key_value_select_n,
  input wire [4:0] logical_page_in,
  input wire [6:0] register_byte_select,
  input wire [7:0] data_in,
  // Outputs.
  input wire [7:0] data_out,
  input wire data_oe,
  input wire [9:0] mapped_page_out,
  input wire mapped_page_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence win_s;
    $past(!register_window_select_n, 3) && $past(read_not_write, 3) &&
      $past(logical_page_in, 3) == 5'h1F;
  endsequence
  sequence key_s;
    data_oe && $past(register_byte_select, 3) inside {[7'h40:7'h47]};
  endsequence
  sequence quiet_s;
    $stable({bus_cycle_end, bus_grant, bus_phase_flag, reset_n, read_not_write,
      register_window_select_n, key_value_select_n, logical_page_in,
      register_byte_select, data_in}) [*8];
  endsequence
  reset_page_a: assert property ($fell(rst) |-> mapped_page_out == 10'h3FF)
    else $error("page not forced after reset");
  reg_page_a: assert property (data_oe |-> mapped_page_out == 10'h3FF)
    else $error("register access page wrong");
  read_cond_a: assert property (data_oe |-> win_s)
    else $error("read outside window");
  reserved_quiet_a: assert property (data_oe |-> $past(register_byte_select, 3) < 7'h4C)
    else $error("reserved byte answered");
  key_select_a: assert property (key_s |-> !$past(key_value_select_n, 3))
    else $error("identifier read without select");
  key_bits_a: assert property (key_s |-> data_out[7:3] == 5'h00)
    else $error("identifier unused bits set");
  even_bits_a: assert property (data_oe && $past(register_byte_select, 3) < 7'h40 &&
      ($past(register_byte_select, 3) & 7'h01) == 7'h00 |-> data_out[7:2] == 6'h00)
    else $error("even map byte upper bits set");
  page_steady_a: assert property (quiet_s |=> $stable(mapped_page_out))
    else $error("page moved with steady inputs");
endmodule // task_page_mapper_chk
bind task_page_mapper task_page_mapper_chk chk_u (.clk(clk), .rst(rst),
  .bus_cycle_end(bus_cycle_end), .bus_grant(bus_grant), .bus_phase_flag(bus_phase_flag),
  .reset_n(reset_n),
  .read_not_write(read_not_write), .register_window_select_n(register_window_select_n),
  .key_value_select_n(key_value_select_n), .logical_page_in(logical_page_in),
  .register_byte_select(register_byte_select), .data_in(data_in), .data_out(data_out),
  .data_oe(data_oe), .mapped_page_out(mapped_page_out), .mapped_page_oe(mapped_page_oe));

/* File: dv/task_page_mapper_tb.sv */
// Self-checking bench for the task page mapper.
`timescale 1ns/1ps
module task_page_mapper_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strobe, rnw, ra_n, kva_n, pin_rst_n, doe, poe;
  logic [1:0] bst;
  logic [4:0] page;
  logic [6:0] rs;
  logic [7:0] wd, dout;
  logic [9:0] pout;
  int err_count = 0;
  int checked = 0;
  int ticks = 0;
  always #4 clk = ~clk;
  cpu_bus_model cpu_u (.clk(clk), .strobe(strobe), .rnw(rnw), .bst(bst),
    .pin_rst_n(pin_rst_n), .page(page), .ra_n(ra_n), .kva_n(kva_n), .rs(rs), .wd(wd));
  task_page_mapper dut_u (.clk(clk), .rst(rst), .bus_cycle_end(strobe),
    .read_not_write(rnw), .bus_grant(bst[1]), .bus_phase_flag(bst[0]),
    .reset_n(pin_rst_n), .logical_page_in(page), .register_window_select_n(ra_n),
    .key_value_select_n(kva_n), .register_byte_select(rs), .data_in(wd),
    .data_out(dout), .data_oe(doe), .mapped_page_out(pout), .mapped_page_oe(poe));
  task automatic complete_run();
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    cpu_u.cyc(2'h0, 1'b0, 5'h1F, 1'b0, 1'b1, a, d);
  endtask
  task automatic rd(input logic [6:0] a, input logic [10:0] e);
    cpu_u.cyc(2'h0, 1'b1, 5'h1F, 1'b0, 1'b0, a, 8'h00);
    check({2'h0, doe, doe ? dout : 8'h00}, e);
  endtask
  task automatic mp(input logic [1:0] s, input logic [10:0] e);
    cpu_u.cyc(s, 1'b1, 5'h05, 1'b1, 1'b1, 7'h00, 8'h00);
    check({poe, poe ? pout : 10'h000}, e);
  endtask
  task automatic reset_state();
    mp(2'h0, 11'h7FF);
    rd(7'h40, 11'h100);
    rd(7'h4A, 11'h100);
    rd(7'h4B, 11'h100);
    wr(7'h4C, 8'h5A);
    rd(7'h4C, 11'h000);
  endtask
  task automatic map_basic();
    wr(7'h0A, 8'h02);
    wr(7'h0B, 8'h34);
    mp(2'h0, 11'h7FF);
    cpu_u.cyc(2'h0, 1'b0, 5'h1F, 1'b0, 1'b0, 7'h40, 8'h00);
    mp(2'h0, 11'h634);
    rd(7'h0A, 11'h102);
    check({1'b1, pout}, 11'h7FF);
    rd(7'h0B, 11'h134);
  endtask
  task automatic dma_task();
    wr(7'h4A, 8'h01);
    wr(7'h0A, 8'h01);
    wr(7'h0B, 8'h55);
    wr(7'h4A, 8'h00);
    mp(2'h3, 11'h555);
    mp(2'h0, 11'h634);
  endtask
  task automatic fuse_switch();
    wr(7'h4A, 8'h02);
    wr(7'h0A, 8'h00);
    wr(7'h0B, 8'hAA);
    wr(7'h4A, 8'h00);
    wr(7'h4B, 8'h02);
    mp(2'h0, 11'h634);
    wr(7'h49, 8'h01);
    mp(2'h3, 11'h555);
    cpu_u.cyc(2'h0, 1'b1, 5'h05, 1'b1, 1'b1, 7'h00, 8'h00);
    cpu_u.cyc(2'h0, 1'b1, 5'h05, 1'b1, 1'b1, 7'h00, 8'h00);
    mp(2'h0, 11'h4AA);
    rd(7'h4B, 11'h000);
    cpu_u.cyc(2'h1, 1'b1, 5'h05, 1'b1, 1'b1, 7'h00, 8'h00);
    mp(2'h0, 11'h634);
  endtask
  task automatic key_mismatch();
    cpu_u.cyc(2'h0, 1'b0, 5'h1F, 1'b0, 1'b0, 7'h40, 8'h01);
    mp(2'h0, 11'h000);
    rd(7'h40, 11'h101);
    rd(7'h0A, 11'h000);
    rd(7'h48, 11'h000);
  endtask
  always @(posedge clk) begin
    ticks++;
    if (ticks == 3000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
    reset_state();
    map_basic();
    dma_task();
    fuse_switch();
    key_mismatch();
    repeat (12) @(posedge clk);
    complete_run();
  end
endmodule // task_page_mapper_tb
